/* File: common/ecv_cfg.svh */
/*
  Constants for the external cache pin and video load controller.
  Assumes a single 125 MHz clock domain.
*/
`ifndef ECV_CFG_SVH
`define ECV_CFG_SVH
`define ECV_TAG_W 8
`define ECV_DUAL_W 5
`define ECV_IDX_LO_W 12
`define ECV_PTR_W 24
`define ECV_INC_W 8
`define ECV_BANK_W 2
`define ECV_SIZE_W 3
`define ECV_MAX_SIZE 3'h5
`define ECV_SYNC_W 3
`define ECV_SETTLE_N 4'h3
`define ECV_DTOE_N 4'h2
`define ECV_RAS_N 4'h4
`endif

/* File: common/ecv_pkg.sv */
/*
  Types shared by the cache pin and video load controller.
  Assumes ecv_cfg.svh is on the include path.
*/
`include "ecv_cfg.svh"
package ecv_pkg;
  typedef enum logic [1:0]
  {
    ECV_IDLE = 2'h0,
    ECV_LOOKUP = 2'h1,
    ECV_WRITE = 2'h2
  } ecv_op_type;

  typedef struct packed
  {
    logic [`ECV_TAG_W-1:0] tag;
    logic [`ECV_DUAL_W-1:0] dual;
    logic dirty;
    logic parity;
  } ecv_tag_type;

  typedef enum logic [5:0]
  {
    ECV_V_IDLE = 6'h01,
    ECV_V_SETTLE = 6'h02,
    ECV_V_RELOAD = 6'h04,
    ECV_V_DTOE = 6'h08,
    ECV_V_RAS = 6'h10,
    ECV_V_INC = 6'h20
  } ecv_vstate_type;
endpackage

/* File: logic/ecv_ctrl.sv */
/*
  External cache SRAM pin driver and VRAM shift-register load sequencer.
  Assumes all inputs, video requests included, are sampled on clk;
  the request inputs still pass through a synchroniser.
*/
`include "ecv_cfg.svh"
module ecv_ctrl
(
  input wire logic clk,
  input wire logic rst,
  input wire ecv_pkg::ecv_op_type cache_op,
  input wire logic [`ECV_IDX_LO_W+`ECV_DUAL_W:0] cache_index,
  input wire ecv_pkg::ecv_tag_type cache_wr_tag,
  input wire logic [`ECV_SIZE_W-1:0] cache_size,
  input wire logic cache_power_save,
  input wire logic [`ECV_PTR_W-1:0] frame_start,
  input wire logic [`ECV_BANK_W-1:0] frame_bank,
  input wire logic [`ECV_INC_W-1:0] addr_increment,
  input wire logic vframe_n,
  input wire logic vrefresh_n,
  input wire logic [`ECV_TAG_W-1:0] cache_tag_bits_in,
  input wire logic [`ECV_DUAL_W-1:0] cache_dual_role_bits_in,
  input wire logic cache_line_modified_in,
  input wire logic cache_tag_parity_in,
  output ecv_pkg::ecv_tag_type cache_rd_tag,
  output logic [`ECV_TAG_W-1:0] cache_tag_bits_out,
  output logic cache_tag_bits_oe,
  output logic [`ECV_DUAL_W-1:0] cache_dual_role_bits_out,
  output logic [`ECV_DUAL_W-1:0] cache_dual_role_bits_oe,
  output logic cache_line_modified_out,
  output logic cache_tag_parity_out,
  output logic cache_tag_parity_oe,
  output logic cache_index_bit12,
  output logic cache_sram_select_n,
  output logic cache_write_strobe_n,
  output logic cache_output_enable_n,
  output logic [`ECV_PTR_W-1:0] video_pointer,
  output logic vram_dtoe_n,
  output logic vram_dsf,
  output logic [3:0] vram_rasa_n,
  output logic [3:0] vram_rasb_n,
  output logic vload_busy
);
  import ecv_pkg::*;

  logic [`ECV_DUAL_W-1:0] index_role;
  logic [`ECV_DUAL_W-1:0] next_dual_oe;
  logic active;
  logic writing;
  logic [`ECV_SYNC_W-1:0] frame_sync;
  logic [`ECV_SYNC_W-1:0] refresh_sync;
  logic frame_latch;
  logic refresh_latch;
  logic frame_prev;
  logic refresh_prev;
  logic is_split;
  logic [1:0] inc_left;
  logic [3:0] count;
  ecv_vstate_type vstate;
  logic [3:0] bank_sel;

  // Sizes beyond the largest saturate to all index
  always_comb
  begin
    index_role = '0;
    for (int i = 0; i < `ECV_DUAL_W; i++)
      if (cache_size > 3'(i) || cache_size >= `ECV_MAX_SIZE)
        index_role[i] = 1'b1;
  end

  assign active = (cache_op != ECV_IDLE);
  assign writing = (cache_op == ECV_WRITE);
  assign next_dual_oe = active ? (index_role | {`ECV_DUAL_W{writing}})
                               : '0;

  // Tag group registered together so parity keeps tag timing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cache_tag_bits_out <= '0;
      cache_tag_bits_oe <= 1'b0;
      cache_line_modified_out <= 1'b0;
      cache_tag_parity_out <= 1'b0;
      cache_tag_parity_oe <= 1'b0;
      cache_dual_role_bits_out <= '0;
      cache_dual_role_bits_oe <= '0;
      cache_index_bit12 <= 1'b0;
    end
    else
    begin
      cache_tag_bits_out <= cache_wr_tag.tag;
      cache_tag_bits_oe <= writing;
      cache_line_modified_out <= cache_wr_tag.dirty;
      cache_tag_parity_out <= cache_wr_tag.parity;
      cache_tag_parity_oe <= writing;
      for (int i = 0; i < `ECV_DUAL_W; i++)
        cache_dual_role_bits_out[i] <= index_role[i]
          ? cache_index[`ECV_IDX_LO_W+1+i] : cache_wr_tag.dual[i];
      cache_dual_role_bits_oe <= next_dual_oe;
      cache_index_bit12 <= cache_index[`ECV_IDX_LO_W];
    end
  end

  // Read-back of the tag group during lookups
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cache_rd_tag <= '0;
    else
    begin
      cache_rd_tag.tag <= cache_tag_bits_in;
      cache_rd_tag.dual <= cache_dual_role_bits_in & ~index_role;
      cache_rd_tag.dirty <= cache_line_modified_in;
      cache_rd_tag.parity <= cache_tag_parity_in;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cache_sram_select_n <= 1'b0;
      cache_write_strobe_n <= 1'b1;
      cache_output_enable_n <= 1'b1;
    end
    else
    begin
      cache_sram_select_n <= ~active & cache_power_save;
      cache_write_strobe_n <= ~writing;
      cache_output_enable_n <= ~(cache_op == ECV_LOOKUP);
    end
  end

  // Synchronisers: the first stage is read only by the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      frame_sync <= '1;
      refresh_sync <= '1;
    end
    else
    begin
      frame_sync <= {frame_sync[`ECV_SYNC_W-2:0], vframe_n};
      refresh_sync <= {refresh_sync[`ECV_SYNC_W-2:0], vrefresh_n};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      frame_prev <= 1'b1;
      refresh_prev <= 1'b1;
    end
    else
    begin
      frame_prev <= frame_sync[`ECV_SYNC_W-1];
      refresh_prev <= refresh_sync[`ECV_SYNC_W-1];
    end
  end

  // Capture is armed only while idle; edges during a load are dropped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      frame_latch <= 1'b0;
      refresh_latch <= 1'b0;
    end
    else if (vstate == ECV_V_IDLE)
    begin
      frame_latch <= frame_prev & ~frame_sync[`ECV_SYNC_W-1];
      refresh_latch <= refresh_prev & ~refresh_sync[`ECV_SYNC_W-1];
    end
    else
    begin
      frame_latch <= 1'b0;
      refresh_latch <= 1'b0;
    end
  end

  always_comb
  begin
    bank_sel = 4'h0;
    bank_sel[frame_bank] = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vstate <= ECV_V_IDLE;
      is_split <= 1'b0;
      inc_left <= 2'h0;
      count <= 4'h0;
      video_pointer <= '0;
      vram_dtoe_n <= 1'b1;
      vram_dsf <= 1'b0;
      vram_rasa_n <= 4'hF;
      vram_rasb_n <= 4'hF;
      vload_busy <= 1'b0;
    end
    else
    begin
      unique case (vstate)
        ECV_V_IDLE:
        begin
          if (frame_latch | refresh_latch)
          begin
            is_split <= ~frame_latch;
            vstate <= ECV_V_SETTLE;
            count <= `ECV_SETTLE_N;
            vload_busy <= 1'b1;
          end
        end
        ECV_V_SETTLE:
        begin
          count <= count - 4'h1;
          if (count == 4'h1)
            vstate <= is_split ? ECV_V_DTOE : ECV_V_RELOAD;
        end
        ECV_V_RELOAD:
        begin
          video_pointer <= frame_start;
          vstate <= ECV_V_DTOE;
        end
        ECV_V_DTOE:
        begin
          vram_dtoe_n <= 1'b0;
          vram_dsf <= is_split;
          count <= `ECV_DTOE_N;
          vstate <= ECV_V_RAS;
        end
        ECV_V_RAS:
        begin
          count <= count - 4'h1;
          // Strobes already low mark the second count, which releases them and moves on to ECV_V_INC
          if (count == 4'h1 && vram_rasa_n == 4'hF)
          begin
            vram_rasa_n <= ~bank_sel;
            vram_rasb_n <= ~bank_sel;
            count <= `ECV_RAS_N;
          end
          else if (count == 4'h1)
          begin
            vram_rasa_n <= 4'hF;
            vram_rasb_n <= 4'hF;
            vram_dtoe_n <= 1'b1;
            inc_left <= is_split ? 2'h1 : 2'h2;
            vstate <= ECV_V_INC;
          end
        end
        ECV_V_INC:
        begin
          video_pointer <= video_pointer
            + `ECV_PTR_W'(addr_increment);
          inc_left <= inc_left - 2'h1;
          if (inc_left == 2'h1)
          begin
            vstate <= ECV_V_IDLE;
            vload_busy <= 1'b0;
          end
        end
        default:
          vstate <= ECV_V_IDLE;
      endcase
    end
  end

  chk_dual_index_out: assert property (@(posedge clk)
    disable iff (rst) (cache_op != ECV_IDLE) |=>
    ((cache_dual_role_bits_oe & $past(index_role)) == $past(index_role)))
    else $error("index role line not driven");
  chk_parity_tag_timing: assert property (@(posedge clk)
    disable iff (rst) cache_tag_parity_oe == cache_tag_bits_oe)
    else $error("parity direction differs from tag");
  chk_select_power: assert property (@(posedge clk)
    disable iff (rst)
    (!cache_power_save || cache_op != ECV_IDLE) |=> !cache_sram_select_n)
    else $error("select released while needed");
  chk_dtoe_before_ras: assert property (@(posedge clk)
    disable iff (rst) $fell(vram_rasa_n[frame_bank]) |-> !$past(vram_dtoe_n))
    else $error("row strobe before transfer line");
  chk_ras_pair: assert property (@(posedge clk)
    disable iff (rst) vram_rasa_n == vram_rasb_n)
    else $error("row strobe pair split");
  chk_reload_first: assert property (@(posedge clk)
    disable iff (rst)
    (vstate == ECV_V_RELOAD) |=> (video_pointer == $past(frame_start)))
    else $error("pointer not reloaded");
  chk_split_dsf: assert property (@(posedge clk)
    disable iff (rst) (vstate == ECV_V_RAS) |-> (vram_dsf == is_split))
    else $error("dsf wrong for load type");
  chk_busy_no_capture: assert property (@(posedge clk)
    disable iff (rst)
    (vstate != ECV_V_IDLE) |=> !frame_latch && !refresh_latch)
    else $error("edge captured during load");
endmodule

/* File: testbench/ecv_sram_model.sv */
/*
  Tag SRAM model that resolves the tag, dual-role, dirty and parity wires.
  Assumes the controller's per-pin enables; released wires carry the stored entry under output enable, else are pulled down.
*/
`include "ecv_cfg.svh"
module ecv_sram_model
(
  input wire logic clk,
  input wire ecv_pkg::ecv_tag_type pin_out,
  input wire logic tag_oe,
  input wire logic [`ECV_DUAL_W-1:0] dual_oe,
  input wire logic par_oe,
  input wire logic cache_write_strobe_n,
  input wire logic cache_output_enable_n,
  output ecv_pkg::ecv_tag_type pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import ecv_pkg::*;
  ecv_tag_type mem;
  ecv_tag_type drv;
  // Write strobe stores what the controller drives
  always_ff @(posedge clk)
  begin
    if (!cache_write_strobe_n) mem <= pin_out;
  end
  // Output enable puts the stored entry on the wires, else pull-down
  assign drv = cache_output_enable_n ? '0 : mem;
  assign pin_in.tag = tag_oe ? pin_out.tag : drv.tag;
  assign pin_in.dirty = tag_oe ? pin_out.dirty : drv.dirty;
  assign pin_in.parity = par_oe ? pin_out.parity : drv.parity;
  assign pin_in.dual = (dual_oe & pin_out.dual) | (~dual_oe & drv.dual);
endmodule

/* File: testbench/test_ecv_ctrl.sv */
/*
  Self-checking bench for the cache pin and video load controller.
  Assumes the controller registers every cache pin one cycle after its inputs.
*/
`include "ecv_cfg.svh"
module test_ecv_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import ecv_pkg::*;
  logic clk = 0;
  logic rst = 1;
  ecv_op_type cache_op = ECV_IDLE;
  logic [17:0] cache_index = '0;
  ecv_tag_type wr = '0;
  ecv_tag_type rd;
  ecv_tag_type po;
  ecv_tag_type pi;
  logic [2:0] cache_size = '0;
  logic power_save = 0;
  logic [23:0] frame_start = 24'h123400;
  logic [1:0] frame_bank = 2'h2;
  logic [7:0] inc = 8'h10;
  logic vframe_n = 1;
  logic vrefresh_n = 1;
  logic tag_oe, par_oe, bit12, sel_n, we_n, oe_n, dtoe_n, dsf, busy;
  logic [4:0] dual_oe;
  logic [23:0] ptr;
  logic [3:0] rasa, rasb;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [4:0] m;
  logic [23:0] ep;
  ecv_ctrl dut
  (
    .clk(clk), .rst(rst), .cache_op(cache_op), .cache_index(cache_index),
    .cache_wr_tag(wr), .cache_size(cache_size),
    .cache_power_save(power_save), .frame_start(frame_start),
    .frame_bank(frame_bank), .addr_increment(inc), .vframe_n(vframe_n),
    .vrefresh_n(vrefresh_n), .cache_tag_bits_in(pi.tag),
    .cache_dual_role_bits_in(pi.dual), .cache_line_modified_in(pi.dirty),
    .cache_tag_parity_in(pi.parity), .cache_rd_tag(rd),
    .cache_tag_bits_out(po.tag), .cache_tag_bits_oe(tag_oe),
    .cache_dual_role_bits_out(po.dual), .cache_dual_role_bits_oe(dual_oe),
    .cache_line_modified_out(po.dirty), .cache_tag_parity_out(po.parity),
    .cache_tag_parity_oe(par_oe), .cache_index_bit12(bit12),
    .cache_sram_select_n(sel_n), .cache_write_strobe_n(we_n),
    .cache_output_enable_n(oe_n), .video_pointer(ptr), .vram_dtoe_n(dtoe_n),
    .vram_dsf(dsf), .vram_rasa_n(rasa), .vram_rasb_n(rasb),
    .vload_busy(busy)
  );
  ecv_sram_model sram
  (
    .clk(clk), .pin_out(po), .tag_oe(tag_oe), .dual_oe(dual_oe),
    .par_oe(par_oe), .cache_write_strobe_n(we_n),
    .cache_output_enable_n(oe_n), .pin_in(pi)
  );
  initial
  begin
    forever #4 clk = ~clk;
  end
  task check(input logic [63:0] s, input logic [63:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  // One video load; stray edges while busy must leave no second load
  task vload(input logic frm, input logic [23:0] exp);
    int i;
    int nras;
    logic pd;
    @(posedge clk);
    if (frm) vframe_n <= 0;
    else vrefresh_n <= 0;
    i = 0;
    while (busy !== 1'b1 && i < 20)
    begin
      tick();
      i++;
    end
    check(busy, 1);
    @(posedge clk);
    vframe_n <= 0;
    vrefresh_n <= 0;
    #1;
    nras = 0;
    pd = 1;
    i = 0;
    while (busy === 1'b1 && i < 60)
    begin
      if (rasa !== 4'hF)
      begin
        nras++;
        check({rasa, rasb, dtoe_n, dsf, pd},
          {~(4'h1 << frame_bank), ~(4'h1 << frame_bank), 1'b0, ~frm,
          1'b0});
      end
      pd = dtoe_n;
      tick();
      i++;
    end
    check(nras, `ECV_RAS_N);
    check(ptr, exp);
    @(posedge clk);
    vframe_n <= 1;
    vrefresh_n <= 1;
    repeat (10) tick();
    check({busy, ptr}, {1'b0, exp});
    $display("video load test done");
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    tick();
    check({sel_n, we_n, oe_n, dtoe_n, rasa, rasb, busy, ptr},
      {3'b011, 1'b1, 8'hFF, 1'b0, 24'h0});
    $display("reset test done");
    repeat (2) @(posedge clk);
    rst <= 0;
    power_save <= 1;
    for (int s = 0; s < 7; s++)
    begin
      m = (s >= 5) ? 5'h1F : 5'((1 << s) - 1);
      @(posedge clk);
      cache_size <= 3'(s);
      cache_op <= ECV_WRITE;
      cache_index <= {5'h0A ^ 5'(s), 1'(s), 12'h0};
      wr <= {8'hA5 ^ 8'(s), 5'h15, 1'b1, 1'(s)};
      @(posedge clk);
      cache_op <= ECV_LOOKUP;
      #1;
      check({sel_n, we_n, oe_n, tag_oe, par_oe, dual_oe},
        {3'b001, 2'b11, 5'h1F});
      check({po.tag, po.dirty, po.parity, bit12}, {wr.tag, wr.dirty,
        wr.parity, cache_index[12]});
      check(po.dual, (cache_index[17:13] & m) | (wr.dual & ~m));
      tick();
      check({sel_n, we_n, oe_n, tag_oe, par_oe, dual_oe, bit12},
        {3'b010, 2'b00, m, cache_index[12]});
      @(posedge clk);
      cache_op <= ECV_IDLE;
      #1;
      check(rd, {wr.tag, wr.dual & ~m, wr.dirty, wr.parity});
    end
    $display("cache pin test done");
    repeat (2) tick();
    check({sel_n, tag_oe, par_oe, dual_oe}, {3'b100, 5'h0});
    @(posedge clk);
    power_save <= 0;
    repeat (2) tick();
    check(sel_n, 0);
    $display("select test done");
    ep = 24'(inc);
    vload(0, ep);
    ep = frame_start + 24'(inc) + 24'(inc);
    vload(1, ep);
    @(posedge clk);
    frame_bank <= 2'h1;
    ep = ep + 24'(inc);
    vload(0, ep);
    stop_test();
  end
endmodule
